/* File: hw/pcfg_defs.svh */
// register offsets, field positions and reset values of the port block
`ifndef PCFG_DEFS_SVH
`define PCFG_DEFS_SVH
`define PCFG_OFF_LATCH0 4'h0
`define PCFG_OFF_LATCH1 4'h1
`define PCFG_OFF_LATCH2 4'h2
`define PCFG_OFF_MODE_A0 4'h3
`define PCFG_OFF_MODE_B0 4'h4
`define PCFG_OFF_MODE_A1 4'h5
`define PCFG_OFF_MODE_B1 4'h6
`define PCFG_OFF_MODE_A2 4'h7
`define PCFG_OFF_MODE_B2 4'h8
`define PCFG_OFF_KEY_EN 4'h9
`define PCFG_OFF_AUX 4'hA
`define PCFG_OFF_PIN0 4'hB
`define PCFG_OFF_PIN1 4'hC
`define PCFG_OFF_PIN2 4'hD
`define PCFG_AUX_KEY_IE 0
`define PCFG_AUX_KEY_FLAG 1
`define PCFG_P2M_CLK_OUT 2
`define PCFG_P2M_T0_TOG 3
`define PCFG_P2M_T1_TOG 4
`define PCFG_P2M_SCHMITT0 5
`define PCFG_MODE_RST 8'h00
`define PCFG_LATCH_RST 8'hFF
`define PCFG_STRONG_CYC 2'h2
`define PCFG_P2_PRESENT 8'h03
`endif

/* File: hw/pcfg_pkg.sv */
// types of the port configuration block
package pcfg_pkg;
  typedef enum logic [1:0] {
    PCFG_QUASI = 2'h0,
    PCFG_PUSH_PULL = 2'h1,
    PCFG_INPUT_ONLY = 2'h2,
    PCFG_OPEN_DRAIN = 2'h3
  } pcfg_mode_t;
  typedef logic [2:0][7:0] pcfg_port_t;
endpackage : pcfg_pkg

/* File: hw/pcfg_port.sv */
// port drive configuration, pull-up sequencing and keypad wake logic
// Behaviour
// - two mode bits per pin: 00 quasi, 01 push-pull, 10 input only, 11 open drain
// - after reset every configurable pin is quasi-bidirectional
// - quasi mode: very weak pull-up on whenever latch is one
// - quasi mode: weak pull-up on only while latch and sensed pin are one
// - quasi latch rising 0 to 1 gives strong pull-up for exactly two clocks
// - open drain: no pull-ups, pull-down only while latch is zero
// - push-pull: strong pull-up while latch one, pull-down while latch zero
// - port 1 bits 2 and 3 are always open drain, inputs when latched one
// - port 1 bit 5 is input only, usable only with internal reset selected
// - crystal oscillator selected disables port 2 bits 0 and 1 entirely
// - port reset level follows reset-level config bit; high pins are quasi
// - per-port TTL or Schmitt select; port 1 bits 2, 3, 5 always Schmitt
// - spare port 2 mode register one bits: Schmitt, timer toggles, clock out
// - each port 0 pin has its own keypad enable bit
// - any enabled port 0 pin low sets keypad flag; interrupt if enabled
// - keypad interrupt wakes the CPU from idle and power down
`timescale 1ns/10ps
`default_nettype none
`include "pcfg_defs.svh"
module pcfg_port
  import pcfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic reset_level_high_select,
  input wire logic crystal_osc_select,
  input wire logic internal_reset_select,
  input wire pcfg_port_t pin_in,
  output pcfg_port_t pin_out,
  output pcfg_port_t pin_oe_n,
  output pcfg_port_t very_weak_pu,
  output pcfg_port_t weak_pu,
  output pcfg_port_t strong_pu,
  output pcfg_port_t pull_dn,
  output pcfg_port_t schmitt_sel,
  output logic timer0_toggle_enable,
  output logic timer1_toggle_enable,
  output logic clock_output_enable,
  output logic keypad_irq,
  output logic keypad_wake
);
  pcfg_port_t latch_q, latch_d;
  pcfg_port_t port_mode_select_a, port_mode_select_b;
  pcfg_port_t sync1_q, sync2_q, pin_rd;
  pcfg_port_t strong_hit;
  logic [7:0] keypad_pin_enable_reg;
  logic [7:0] auxiliary_control_one;
  logic [7:0] rdata_q;
  logic keypad_flag, key_ie, key_hit, flag_clr;
  logic level_loaded_q;
  logic [2:0][7:0] present;

  assign present = {`PCFG_P2_PRESENT, 8'hFF, 8'hFF};

  // latch write path; reset-level strap caught in the first clock after release
  always_comb begin
    latch_d = latch_q;
    if (!level_loaded_q) begin
      latch_d = reset_level_high_select ? {3{8'hFF}} : {3{8'h00}};
    end else if (reg_we) begin
      case (reg_addr)
        `PCFG_OFF_LATCH0: latch_d[0] = reg_wdata;
        `PCFG_OFF_LATCH1: latch_d[1] = reg_wdata;
        `PCFG_OFF_LATCH2: latch_d[2] = reg_wdata;
        default: latch_d = latch_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch_q <= {3{`PCFG_LATCH_RST}};
      level_loaded_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
      level_loaded_q <= 1'b1;
    end
  end

  // mode registers; zero means quasi-bidirectional
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      port_mode_select_a <= {3{`PCFG_MODE_RST}};
      port_mode_select_b <= {3{`PCFG_MODE_RST}};
      keypad_pin_enable_reg <= 8'h00;
    end else if (reg_we) begin
      case (reg_addr)
        `PCFG_OFF_MODE_A0: port_mode_select_a[0] <= reg_wdata;
        `PCFG_OFF_MODE_B0: port_mode_select_b[0] <= reg_wdata;
        `PCFG_OFF_MODE_A1: port_mode_select_a[1] <= reg_wdata;
        `PCFG_OFF_MODE_B1: port_mode_select_b[1] <= reg_wdata;
        `PCFG_OFF_MODE_A2: port_mode_select_a[2] <= reg_wdata;
        `PCFG_OFF_MODE_B2: port_mode_select_b[2] <= reg_wdata;
        `PCFG_OFF_KEY_EN: keypad_pin_enable_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  assign clock_output_enable = port_mode_select_a[2][`PCFG_P2M_CLK_OUT];
  assign timer0_toggle_enable = port_mode_select_a[2][`PCFG_P2M_T0_TOG];
  assign timer1_toggle_enable = port_mode_select_a[2][`PCFG_P2M_T1_TOG];

  // pins are asynchronous to the core; two flops before any use
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= {3{8'h00}};
      sync2_q <= {3{8'h00}};
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  genvar gp, gb;
  generate
    for (gp = 0; gp < 3; gp++) begin : g_port
      for (gb = 0; gb < 8; gb++) begin : g_bit
        pcfg_mode_t mode;
        logic fixed_od, fixed_in, lost, drv_ok;
        logic [1:0] strong_cnt_q;
        logic rise;
        assign fixed_od = (gp == 1) && (gb == 2 || gb == 3);
        assign fixed_in = (gp == 1) && (gb == 5);
        assign lost = (gp == 2) && (gb < 2) && crystal_osc_select;
        assign drv_ok = present[gp][gb] && !lost && !fixed_in;
        always_comb begin
          if (fixed_od) begin
            mode = PCFG_OPEN_DRAIN;
          end else begin
            mode = pcfg_mode_t'({port_mode_select_a[gp][gb],
                                 port_mode_select_b[gp][gb]});
          end
        end
        assign rise = !latch_q[gp][gb] && latch_d[gp][gb] && mode == PCFG_QUASI;
        // counter reloads on each new rise, so a quick 1-0-1 still gets 2 clocks
        always_ff @(posedge ref_clk or posedge rst) begin
          if (rst) begin
            strong_cnt_q <= 2'h0;
          end else if (rise) begin
            strong_cnt_q <= `PCFG_STRONG_CYC;
          end else if (strong_cnt_q != 2'h0) begin
            strong_cnt_q <= strong_cnt_q - 2'h1;
          end
        end
        assign strong_hit[gp][gb] = strong_cnt_q != 2'h0 && mode == PCFG_QUASI;
        assign very_weak_pu[gp][gb] = drv_ok && mode == PCFG_QUASI
                                      && latch_q[gp][gb];
        assign weak_pu[gp][gb] = drv_ok && mode == PCFG_QUASI && latch_q[gp][gb]
                                 && sync2_q[gp][gb];
        assign strong_pu[gp][gb] = drv_ok && ((mode == PCFG_PUSH_PULL && latch_q[gp][gb])
                                   || (strong_hit[gp][gb] && latch_q[gp][gb]));
        assign pull_dn[gp][gb] = drv_ok && mode != PCFG_INPUT_ONLY
                                 && !latch_q[gp][gb];
        assign pin_out[gp][gb] = !pull_dn[gp][gb];
        assign pin_oe_n[gp][gb] = !(pull_dn[gp][gb] || strong_pu[gp][gb]);
        assign pin_rd[gp][gb] = present[gp][gb] && !lost
                                && !(fixed_in && !internal_reset_select)
                                && sync2_q[gp][gb];
        assign schmitt_sel[gp][gb] = fixed_od || fixed_in
                                     || port_mode_select_a[2][`PCFG_P2M_SCHMITT0 + gp];
      end
    end
  endgenerate

  // keypad flag: set has priority over a software clear in the same cycle
  assign key_hit = |(keypad_pin_enable_reg & ~sync2_q[0]);
  assign flag_clr = reg_we && reg_addr == `PCFG_OFF_AUX
                    && !reg_wdata[`PCFG_AUX_KEY_FLAG];
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      keypad_flag <= 1'b0;
      key_ie <= 1'b0;
    end else begin
      if (key_hit) begin
        keypad_flag <= 1'b1;
      end else if (flag_clr) begin
        keypad_flag <= 1'b0;
      end
      if (reg_we && reg_addr == `PCFG_OFF_AUX) begin
        key_ie <= reg_wdata[`PCFG_AUX_KEY_IE];
      end
    end
  end
  assign keypad_irq = keypad_flag && key_ie;
  // the pin path runs through the synchroniser and the keypad_flag flop, both on ref_clk; wake is the level request
  assign keypad_wake = keypad_irq;

  always_comb begin
    auxiliary_control_one = 8'h00;
    auxiliary_control_one[`PCFG_AUX_KEY_IE] = key_ie;
    auxiliary_control_one[`PCFG_AUX_KEY_FLAG] = keypad_flag;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_re) begin
      case (reg_addr)
        `PCFG_OFF_LATCH0: rdata_q <= latch_q[0];
        `PCFG_OFF_LATCH1: rdata_q <= latch_q[1];
        `PCFG_OFF_LATCH2: rdata_q <= latch_q[2];
        `PCFG_OFF_MODE_A0: rdata_q <= port_mode_select_a[0];
        `PCFG_OFF_MODE_B0: rdata_q <= port_mode_select_b[0];
        `PCFG_OFF_MODE_A1: rdata_q <= port_mode_select_a[1];
        `PCFG_OFF_MODE_B1: rdata_q <= port_mode_select_b[1];
        `PCFG_OFF_MODE_A2: rdata_q <= port_mode_select_a[2];
        `PCFG_OFF_MODE_B2: rdata_q <= port_mode_select_b[2];
        `PCFG_OFF_KEY_EN: rdata_q <= keypad_pin_enable_reg;
        `PCFG_OFF_AUX: rdata_q <= auxiliary_control_one;
        `PCFG_OFF_PIN0: rdata_q <= pin_rd[0];
        `PCFG_OFF_PIN1: rdata_q <= pin_rd[1];
        `PCFG_OFF_PIN2: rdata_q <= pin_rd[2];
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_mode_reset: assert property ($rose(level_loaded_q) |-> port_mode_select_a == '0
    && port_mode_select_b == '0) else $error("modes not quasi after reset");
  a_strong_two: assert property ($rose(latch_q[0][0]) && port_mode_select_a[0][0] == 1'b0
    && port_mode_select_b[0][0] == 1'b0 && $stable(port_mode_select_a[0][0])
    && $stable(port_mode_select_b[0][0])
    |-> strong_pu[0][0] [*2] ##1 (!strong_pu[0][0] || !latch_q[0][0]))
    else $error("strong pull-up not two clocks");
  a_vweak_quasi: assert property (port_mode_select_a[0][3] == 1'b0
    && port_mode_select_b[0][3] == 1'b0 |-> very_weak_pu[0][3] == latch_q[0][3])
    else $error("very weak pull-up wrong");
  a_weak_pin: assert property (weak_pu[1][0] |-> latch_q[1][0] && sync2_q[1][0])
    else $error("weak pull-up without pin high");
  a_od_nopull: assert property (port_mode_select_a[0][1] && port_mode_select_b[0][1]
    |-> !very_weak_pu[0][1] && !weak_pu[0][1] && !strong_pu[0][1]
    && pull_dn[0][1] == !latch_q[0][1]) else $error("open drain drive wrong");
  a_pp_drive: assert property (!port_mode_select_a[0][2] && port_mode_select_b[0][2]
    |-> strong_pu[0][2] == latch_q[0][2] && pull_dn[0][2] == !latch_q[0][2])
    else $error("push-pull drive wrong");
  a_fixed_od: assert property (!strong_pu[1][2] && !weak_pu[1][3]
    && schmitt_sel[1][2] && schmitt_sel[1][5]) else $error("fixed pin misconfigured");
  a_xtal_off: assert property (crystal_osc_select |-> pin_oe_n[2][1:0] == 2'h3)
    else $error("crystal pins driven");
  a_p15_read: assert property (!internal_reset_select && reg_re
    && reg_addr == `PCFG_OFF_PIN1 |=> !reg_rdata[5]) else $error("port1 bit5 read");
  a_key_set: assert property (key_hit |=> keypad_flag) else $error("flag not set");
  a_key_hold: assert property (keypad_flag && !flag_clr |=> keypad_flag)
    else $error("flag cleared by hardware");
  a_key_sync: assert property (keypad_pin_enable_reg[0] && $stable(keypad_pin_enable_reg)
    && !pin_in[0][0] ##1 !pin_in[0][0] |-> ##[1:2] keypad_flag)
    else $error("keypad press missed");
  a_wake_irq: assert property (keypad_flag && key_ie |-> keypad_wake && keypad_irq)
    else $error("no wake on keypad");
  // single sample bits stand for the rest; every pin runs the same generate body
  a_reset_level: assert property ($rose(level_loaded_q) |-> latch_q
    == {24{$past(reset_level_high_select)}}) else $error("latch reset level wrong");
  a_input_only: assert property (port_mode_select_a[0][4] && !port_mode_select_b[0][4]
    |-> pin_oe_n[0][4] && !very_weak_pu[0][4] && !weak_pu[0][4] && !strong_pu[0][4])
    else $error("input only pin driven");
  a_weak_on: assert property (!port_mode_select_a[0][5] && !port_mode_select_b[0][5]
    && latch_q[0][5] && sync2_q[0][5] |-> weak_pu[0][5])
    else $error("weak pull-up missing");
  a_pd_quasi: assert property (!port_mode_select_a[0][6] && !port_mode_select_b[0][6]
    |-> pull_dn[0][6] == !latch_q[0][6] && very_weak_pu[0][6] == latch_q[0][6])
    else $error("quasi pull-down wrong");
  a_pp_strong: assert property (!port_mode_select_a[1][0] && port_mode_select_b[1][0]
    && latch_q[1][0] |-> strong_pu[1][0] && !pull_dn[1][0] && !pin_oe_n[1][0])
    else $error("push-pull high not strong");
  a_od_pin13: assert property (pull_dn[1][3] == !latch_q[1][3] && !very_weak_pu[1][3])
    else $error("port1 bit3 not open drain");
  a_p15_idle: assert property (pin_oe_n[1][5] && !very_weak_pu[1][5] && !weak_pu[1][5])
    else $error("port1 bit5 driven");
  a_schmitt_port: assert property (port_mode_select_a[2][`PCFG_P2M_SCHMITT0]
    |-> schmitt_sel[0] == 8'hFF) else $error("port0 schmitt select wrong");
  a_xtal_read: assert property (crystal_osc_select && reg_re
    && reg_addr == `PCFG_OFF_PIN2 |=> reg_rdata[1:0] == 2'h0) else $error("crystal pins read");
  a_key_enable: assert property (keypad_pin_enable_reg == 8'h00 && !keypad_flag
    |=> !keypad_flag) else $error("flag set with no pin enabled");
  a_irq_gate: assert property (!key_ie |-> !keypad_irq)
    else $error("keypad interrupt while disabled");
  a_wake_idle: assert property (!keypad_flag |-> !keypad_wake)
    else $error("wake without keypad flag");

  c_strong_pulse: cover property ($rose(strong_pu[0][0]));
  c_key_irq: cover property ($rose(keypad_irq));
  c_set_clear: cover property (key_hit && flag_clr);
  c_od_input: cover property (latch_q[1][2] && !sync2_q[1][2]);
  c_push_pull: cover property (strong_pu[1][0] && latch_q[1][0]);
endmodule : pcfg_port
`default_nettype wire

/* File: verification/pcfg_pin_model.sv */
// pin model: keypad switches and loose pins facing the port block
`timescale 1ns/10ps
`default_nettype none
module pcfg_pin_model
  import pcfg_pkg::*;
(
  input wire pcfg_port_t pin_out,
  input wire pcfg_port_t pin_oe_n,
  input wire pcfg_port_t very_weak_pu,
  input wire pcfg_port_t weak_pu,
  input wire pcfg_port_t strong_pu,
  input wire pcfg_port_t ext_en,
  input wire pcfg_port_t ext_val,
  input wire pcfg_port_t flt,
  output wire pcfg_port_t pin_level
);
  wire pcfg_port_t pu = very_weak_pu | weak_pu | strong_pu;
  // a closed key overpowers a very weak or weak pull-up but not a pin the block drives; an undriven pin wanders
  assign pin_level = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
    | (pin_oe_n & ~ext_en & pu) | (pin_oe_n & ~ext_en & ~pu & flt);
endmodule : pcfg_pin_model
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench of the port configuration block
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import pcfg_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst, reg_we, reg_re, reset_level_high_select, crystal_osc_select;
  logic internal_reset_select, timer0_toggle_enable, timer1_toggle_enable;
  logic clock_output_enable, keypad_irq, keypad_wake;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, l;
  pcfg_port_t pin_in, pin_out, pin_oe_n, very_weak_pu, weak_pu, strong_pu;
  pcfg_port_t pull_dn, schmitt_sel, ext_en, ext_val, flt;
  int errors, comparisons, cyc;
  int unsigned sd;
  always #5 ref_clk = ~ref_clk;
  pcfg_port pcfg_port_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .reset_level_high_select(reset_level_high_select), .crystal_osc_select(crystal_osc_select),
    .internal_reset_select(internal_reset_select), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .very_weak_pu(very_weak_pu), .weak_pu(weak_pu),
    .strong_pu(strong_pu), .pull_dn(pull_dn), .schmitt_sel(schmitt_sel),
    .timer0_toggle_enable(timer0_toggle_enable), .timer1_toggle_enable(timer1_toggle_enable),
    .clock_output_enable(clock_output_enable), .keypad_irq(keypad_irq),
    .keypad_wake(keypad_wake));
  pcfg_pin_model pcfg_pin_model_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .very_weak_pu(very_weak_pu), .weak_pu(weak_pu), .strong_pu(strong_pu),
    .ext_en(ext_en), .ext_val(ext_val), .flt(flt), .pin_level(pin_in));
  task automatic complete_run;
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_re <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask : rd
  task automatic do_reset;
    rst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : do_reset
  // expected drive: 0 very weak, 1 weak, 2 strong, 3 pull-down
  function automatic logic [7:0] exp_drv(input int k, input logic [1:0] m, input logic [7:0] v);
    case (k)
      0, 1: return (m == 2'h0) ? v : 8'h00;
      2: return (m == 2'h1) ? v : 8'h00;
      default: return (m != 2'h2) ? ~v : 8'h00;
    endcase
  endfunction : exp_drv
  always @(posedge ref_clk) begin
    flt <= pcfg_port_t'({$urandom, $urandom});
    cyc++;
    if (cyc == 4000) begin
      errors++;
      complete_run;
    end
  end
  initial begin
    sd = $urandom(32'h05B44C51);
    {rst, reg_we, reg_re, reg_addr, reg_wdata} = {3'h4, 4'h0, 8'h00};
    {reset_level_high_select, crystal_osc_select, internal_reset_select} = 3'h4;
    {ext_en, ext_val, flt} = '0;
    do_reset;
    for (int a = 0; a < 2; a++) rd(a[3:0], 8'hFF);
    for (int a = 3; a < 9; a++) rd(a[3:0], 8'h00);
    rd(4'hE, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h01);
    #1 chk("strong_pu", 8'h01, strong_pu[0]);
    tick(1);
    chk("strong_pu", 8'h01, strong_pu[0]);
    tick(1);
    chk("strong_pu", 8'h00, strong_pu[0]);
    for (int m = 0; m < 4; m++) repeat (3) begin
      l = 8'($urandom);
      wr(4'h3, {8{m[1]}});
      wr(4'h4, {8{m[0]}});
      wr(4'h0, l);
      tick(4);
      chk("very_weak_pu", exp_drv(0, m[1:0], l), very_weak_pu[0]);
      chk("weak_pu", exp_drv(1, m[1:0], l), weak_pu[0]);
      chk("strong_pu", exp_drv(2, m[1:0], l), strong_pu[0]);
      chk("pull_dn", exp_drv(3, m[1:0], l), pull_dn[0]);
      chk("pin_oe_n", ~(exp_drv(2, m[1:0], l) | exp_drv(3, m[1:0], l)), pin_oe_n[0]);
      chk("pin_out", ~exp_drv(3, m[1:0], l), pin_out[0]);
    end
    wr(4'h3, 8'h00);
    wr(4'h4, 8'h00);
    wr(4'h0, 8'hFF);
    @(posedge ref_clk) ext_en[0] <= 8'h04;
    wr(4'h9, 8'h01);
    wr(4'hA, 8'h01);
    tick(5);
    chk("weak_pu", 8'hFB, weak_pu[0]);
    chk("keypad_irq", 8'h00, {7'h00, keypad_irq});
    @(posedge ref_clk) ext_en[0] <= 8'h05;
    tick(4);
    chk("keypad_wake", 8'h03, {6'h00, keypad_irq, keypad_wake});
    @(posedge ref_clk) ext_en[0] <= 8'h00;
    tick(4);
    rd(4'hA, 8'h03);
    wr(4'hA, 8'h01);
    tick(1);
    chk("keypad_irq", 8'h00, {7'h00, keypad_irq});
    wr(4'hA, 8'h00);
    @(posedge ref_clk) ext_en[0] <= 8'h01;
    tick(4);
    chk("keypad_irq", 8'h00, {7'h00, keypad_irq});
    rd(4'hA, 8'h02);
    wr(4'hA, 8'h00);
    rd(4'hA, 8'h02);
    wr(4'h6, 8'hFF);
    wr(4'h1, 8'hFF);
    tick(4);
    chk("strong_pu", 8'hD3, strong_pu[1]);
    wr(4'h1, 8'h00);
    tick(1);
    chk("pull_dn", 8'hDF, pull_dn[1]);
    @(posedge ref_clk) ext_en[1] <= 8'h20;
    ext_val[1] <= 8'h20;
    internal_reset_select <= 1'b0;
    tick(4);
    rd(4'hC, 8'h00);
    @(posedge ref_clk) internal_reset_select <= 1'b1;
    tick(4);
    rd(4'hC, 8'h20);
    wr(4'h2, 8'h00);
    tick(2);
    chk("pull_dn", 8'h03, pull_dn[2]);
    @(posedge ref_clk) crystal_osc_select <= 1'b1;
    tick(4);
    chk("pull_dn", 8'h00, pull_dn[2]);
    rd(4'hD, 8'h00);
    wr(4'h7, 8'hFC);
    tick(1);
    chk("schmitt_sel", 8'hFF, schmitt_sel[0]);
    chk("toggles", 8'h07, {5'h00, timer0_toggle_enable, timer1_toggle_enable,
      clock_output_enable});
    wr(4'h7, 8'h00);
    tick(1);
    chk("schmitt_sel", 8'h2C, schmitt_sel[1]);
    @(posedge ref_clk) reset_level_high_select <= 1'b0;
    do_reset;
    tick(1);
    rd(4'h0, 8'h00);
    chk("pull_dn", 8'hFF, pull_dn[0]);
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
